// file: nvp_guard.sv
// Purpose: memory and access guard for a two-network digital potentiometer
// Assumes: requests arrive decoded on i_clk; i_protect_n from a pin
// Notes: nv writes land in the array when the write cycle ends;
// inc and dec on an nv cell are acknowledged but change nothing;
// a hv strobe rewrites all three hidden bits at once;
// the pin needs three clocks to reach the status word
//
// How it works
// - three hidden nv config bits held
// - protection refuses every nonvolatile write
// - nv write needs pin and bit clear
// - protect bit changes only via hv
// - volatile writes ignore write protection
// - status word readable at address 05h
// - status bits 8..4 read one
// - busy bit; only volatile addresses served
// - net1 lock blocks wiper1, terminal_control_reg 7:4
// - net0 lock blocks wiper0, terminal_control_reg 3:0
// - locks change only via hv command
// - lock status mirrors nv bits, reload
// - status bit0 is pin or bit
// - status address ignores writes
`timescale 1ns/10ps
module nvp_guard #(
	parameter int NV_CYCLES = nvp_pkg::NV_WRITE_CYCLES
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// external protect pin, active low, asynchronous
	input wire logic i_protect_n,
	// serial command request
	input wire logic i_req_valid,
	input wire nvp_pkg::nvp_req_t i_req,
	// high-voltage configuration command
	input wire logic i_hv_valid,
	input wire nvp_pkg::nvp_cfg_t i_hv_cfg,
	// nonvolatile image of the config bits, read at reset release
	input wire nvp_pkg::nvp_cfg_t i_cfg_nv,
	// answer
	output logic o_ack,
	output logic o_refused,
	output logic [8:0] o_rdata,
	// outputs to the resistor networks and the status word
	output logic [8:0] o_wiper0,
	output logic [8:0] o_wiper1,
	output logic [8:0] o_term_ctrl,
	output logic [8:0] o_status
);

	// ==========================================================
	// storage
	// one 16-word array; the status slot stays unused
	logic [8:0] mem [0:15];
	nvp_pkg::nvp_cfg_t cfg;
	logic cfg_loaded;
	logic pin_meta;
	logic pin_sync;
	logic nv_busy;
	logic nv_done;
	logic nv_start;
	logic [3:0] nv_addr;
	logic [8:0] nv_data;

	// ==========================================================
	// helpers
	// nonvolatile cells: both nv wipers and every general-purpose word
	function automatic logic is_nv_addr(input logic [3:0] a);
		is_nv_addr = (a == nvp_pkg::ADDR_NV_WIPER0) ||
			(a == nvp_pkg::ADDR_NV_WIPER1) ||
			(a >= nvp_pkg::ADDR_GP_FIRST);
	endfunction : is_nv_addr

	// saturating step: inc stops at all ones, dec at zero
	function automatic logic [8:0] step(input logic [8:0] v,
			input nvp_pkg::nvp_cmd_t c);
		step = v;
		if (c == nvp_pkg::NVP_CMD_INC && v != nvp_pkg::TERM_CTRL_RESET)
			step = v + 9'h001;
		else if (c == nvp_pkg::NVP_CMD_DEC && v != 9'h000)
			step = v - 9'h001;
	endfunction : step

	// true when a request aims at either wiper cell of one network
	function automatic logic wiper_of(input logic [3:0] a,
			input logic [3:0] vol_a, input logic [3:0] nv_a);
		wiper_of = (a == vol_a) || (a == nv_a);
	endfunction : wiper_of

	// ==========================================================
	// pin synchroniser
	// resets to the idle level so no false protect follows reset
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_meta <= 1'b1;
			pin_sync <= 1'b1;
		end else begin
			pin_meta <= i_protect_n;
			pin_sync <= pin_meta;
		end
	end

	// ==========================================================
	// hidden config bits
	// the image is read once, on the first edge after reset;
	// a hv strobe on that loading edge is lost, the image wins
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cfg <= '0;
			cfg_loaded <= 1'b0;
		end else if (!cfg_loaded) begin
			cfg <= i_cfg_nv;
			cfg_loaded <= 1'b1;
		end else if (i_hv_valid) begin
			cfg <= i_hv_cfg;
		end
	end

	// ==========================================================
	// access decision
	logic wr_like;
	logic protected_nv;
	logic nv_req;
	logic lock_hit;
	logic busy_block;
	logic refuse;
	logic [8:0] term_mask;
	logic [8:0] cur;
	logic [8:0] next_val;

	always_comb begin
		wr_like = (i_req.cmd != nvp_pkg::NVP_CMD_READ);
		protected_nv = !pin_sync || cfg.protect;
		nv_req = is_nv_addr(i_req.addr);
		busy_block = nv_busy && nv_req;
		// a lock names both wiper cells and its terminal nibble
		lock_hit = 1'b0;
		term_mask = 9'h1FF;
		if (cfg.net0_lock) begin
			if (wiper_of(i_req.addr, nvp_pkg::ADDR_VOL_WIPER0,
					nvp_pkg::ADDR_NV_WIPER0))
				lock_hit = 1'b1;
			term_mask = term_mask & ~nvp_pkg::TERM_NET0_MASK;
		end
		if (cfg.net1_lock) begin
			if (wiper_of(i_req.addr, nvp_pkg::ADDR_VOL_WIPER1,
					nvp_pkg::ADDR_NV_WIPER1))
				lock_hit = 1'b1;
			term_mask = term_mask & ~nvp_pkg::TERM_NET1_MASK;
		end
		refuse = busy_block || (wr_like &&
			(lock_hit || (nv_req && protected_nv)));
	end

	// new cell value; a locked nibble of the terminal word keeps its
	// old bits, so such a write is acknowledged rather than refused
	always_comb begin
		cur = mem[i_req.addr];
		next_val = step(cur, i_req.cmd);
		if (i_req.cmd == nvp_pkg::NVP_CMD_WRITE)
			next_val = i_req.data;
		if (i_req.addr == nvp_pkg::ADDR_TERM_CTRL)
			next_val = (next_val & term_mask) | (cur & ~term_mask);
	end

	// ==========================================================
	// acceptance
	logic accept;
	logic accept_put;
	logic accept_read;

	// one decode shared by the timer, the array and the answer
	assign accept = i_req_valid && !refuse;
	assign accept_put = accept && wr_like;
	assign accept_read = accept && !wr_like;

	// nv cycles start only for accepted nv writes; inc and dec on an
	// nv cell are acknowledged but leave it alone
	// refused writes never start a cycle
	assign nv_start = accept_put && nv_req &&
		i_req.cmd == nvp_pkg::NVP_CMD_WRITE;

	// one timer for the array: only one nv cycle runs at a time
	nvp_nv_timer #(
		.CYCLES(NV_CYCLES)
	) u_timer (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_start(nv_start),
		.o_busy(nv_busy),
		.o_done(nv_done)
	);

	// ==========================================================
	// pending nv write: address and data wait for the cycle end
	// only one can wait, since nv cells refuse while busy
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			nv_addr <= 4'h0;
			nv_data <= 9'h000;
		end else if (nv_start) begin
			nv_addr <= i_req.addr;
			nv_data <= i_req.data;
		end
	end

	// ==========================================================
	// memory array; status slot is never stored
	// a volatile write and the end of an nv cycle never share a cell,
	// so both may land on one edge
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < 16; i++) begin
				mem[i] <= nvp_pkg::GP_RESET;
			end
			mem[nvp_pkg::ADDR_VOL_WIPER0] <= nvp_pkg::WIPER_RESET;
			mem[nvp_pkg::ADDR_VOL_WIPER1] <= nvp_pkg::WIPER_RESET;
			mem[nvp_pkg::ADDR_NV_WIPER0] <= nvp_pkg::WIPER_RESET;
			mem[nvp_pkg::ADDR_NV_WIPER1] <= nvp_pkg::WIPER_RESET;
			mem[nvp_pkg::ADDR_TERM_CTRL] <= nvp_pkg::TERM_CTRL_RESET;
		end else begin
			if (nv_done) begin
				mem[nv_addr] <= nv_data;
			end
			if (accept_put && !nv_req &&
					i_req.addr != nvp_pkg::ADDR_PROT_STATUS) begin
				mem[i_req.addr] <= next_val;
			end
		end
	end

	// ==========================================================
	// status word
	logic [8:0] next_status;
	logic [8:0] read_word;

	always_comb begin
		next_status = {nvp_pkg::RESERVED_UPPER_ONES, 4'h0};
		next_status[nvp_pkg::STAT_NV_ACTIVE_BIT] = nv_busy;
		next_status[nvp_pkg::STAT_NET1_LOCK_BIT] = cfg.net1_lock;
		next_status[nvp_pkg::STAT_NET0_LOCK_BIT] = cfg.net0_lock;
		next_status[nvp_pkg::STAT_PROTECT_BIT] = protected_nv;
	end

	// registered so that it lines up with the answer pulses
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_status <= {nvp_pkg::RESERVED_UPPER_ONES, 4'h0};
		end else begin
			o_status <= next_status;
		end
	end

	// ==========================================================
	// answer
	// read mux: the status slot is built, every other slot is stored
	// status at 05h
	assign read_word = (i_req.addr == nvp_pkg::ADDR_PROT_STATUS) ?
		next_status : cur;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_ack <= 1'b0;
			o_refused <= 1'b0;
		end else begin
			o_ack <= accept;
			o_refused <= i_req_valid && refuse;
		end
	end

	// read data holds until the next accepted read
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 9'h000;
		end else if (accept_read) begin
			o_rdata <= read_word;
		end
	end

	// the networks see the array one cycle late, always settled
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_wiper0 <= nvp_pkg::WIPER_RESET;
			o_wiper1 <= nvp_pkg::WIPER_RESET;
			o_term_ctrl <= nvp_pkg::TERM_CTRL_RESET;
		end else begin
			o_wiper0 <= mem[nvp_pkg::ADDR_VOL_WIPER0];
			o_wiper1 <= mem[nvp_pkg::ADDR_VOL_WIPER1];
			o_term_ctrl <= mem[nvp_pkg::ADDR_TERM_CTRL];
		end
	end

endmodule : nvp_guard

// file: nvp_pkg.sv
// Purpose: shared constants and types for the nv write-protect guard
// Assumes: 9-bit memory words, 4-bit word addresses
// Notes: memory map offsets and status layout live here
package nvp_pkg;

	// ==========================================================
	// memory map
	localparam logic [3:0] ADDR_VOL_WIPER0 = 4'h0;
	localparam logic [3:0] ADDR_VOL_WIPER1 = 4'h1;
	localparam logic [3:0] ADDR_NV_WIPER0 = 4'h2;
	localparam logic [3:0] ADDR_NV_WIPER1 = 4'h3;
	localparam logic [3:0] ADDR_TERM_CTRL = 4'h4;
	localparam logic [3:0] ADDR_PROT_STATUS = 4'h5;
	localparam logic [3:0] ADDR_GP_FIRST = 4'h6;

	// ==========================================================
	// status word layout
	localparam int STAT_PROTECT_BIT = 0;
	localparam int STAT_NET0_LOCK_BIT = 1;
	localparam int STAT_NET1_LOCK_BIT = 2;
	localparam int STAT_NV_ACTIVE_BIT = 3;
	localparam logic [4:0] RESERVED_UPPER_ONES = 5'h1F;

	// ==========================================================
	// terminal control: network 1 owns bits 7:4, network 0 bits 3:0
	localparam logic [8:0] TERM_NET1_MASK = 9'h0F0;
	localparam logic [8:0] TERM_NET0_MASK = 9'h00F;
	localparam logic [8:0] TERM_CTRL_RESET = 9'h1FF;
	localparam logic [8:0] WIPER_RESET = 9'h080;
	localparam logic [8:0] GP_RESET = 9'h0FF;

	// ==========================================================
	// nonvolatile write cycle length
	localparam int NV_WRITE_MS = 5;
	localparam int CLK_HZ = 40000000;
	localparam int NV_WRITE_CYCLES = NV_WRITE_MS * (CLK_HZ / 1000);

	// ==========================================================
	// command carrier
	typedef enum logic [1:0] {
		NVP_CMD_WRITE,
		NVP_CMD_INC,
		NVP_CMD_DEC,
		NVP_CMD_READ
	} nvp_cmd_t;

	typedef struct packed {
		nvp_cmd_t cmd;
		logic [3:0] addr;
		logic [8:0] data;
	} nvp_req_t;

	// hidden nonvolatile configuration bits
	typedef struct packed {
		logic net1_lock;
		logic net0_lock;
		logic protect;
	} nvp_cfg_t;

endpackage : nvp_pkg

// file: nvp_nv_timer.sv
// Purpose: busy timer for one nonvolatile write cycle
// Assumes: i_start is a one-cycle pulse on i_clk
// Notes: a start while busy is ignored
`timescale 1ns/10ps
module nvp_nv_timer #(
	parameter int CYCLES = nvp_pkg::NV_WRITE_CYCLES
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// control
	input wire logic i_start,
	// status
	output logic o_busy,
	output logic o_done
);

	logic [31:0] count;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			count <= 32'h0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (o_busy) begin
				if (count == 32'(CYCLES - 1)) begin
					o_busy <= 1'b0;
					o_done <= 1'b1;
					count <= 32'h0;
				end else begin
					count <= count + 32'h1;
				end
			end else if (i_start) begin
				o_busy <= 1'b1;
				count <= 32'h0;
			end
		end
	end

endmodule : nvp_nv_timer

// file: nvp_guard_properties.sv
// Purpose: port checker for the nv write-protect guard
// Assumes: o_status sampled one cycle after a request shows the state used
// Notes: attached by bind at the foot of this file
`timescale 1ns/10ps
module nvp_guard_properties #(
	parameter int NV_CYCLES = 10
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// requests
	input wire logic i_req_valid,
	input wire nvp_pkg::nvp_req_t i_req,
	input wire logic i_hv_valid,
	input wire nvp_pkg::nvp_cfg_t i_hv_cfg,
	// answers
	input wire logic o_ack,
	input wire logic o_refused,
	input wire logic [8:0] o_rdata,
	input wire logic [8:0] o_status
);
	// ==========================================================
	// decode
	logic put;
	logic wr;
	logic nv;
	assign put = i_req_valid && i_req.cmd != nvp_pkg::NVP_CMD_READ;
	assign wr = i_req_valid && i_req.cmd == nvp_pkg::NVP_CMD_WRITE;
	assign nv = i_req.addr inside {4'h2, 4'h3} || i_req.addr >= 4'h6;
	// run length of the busy bit, bounded by the write cycle
	int busy_run;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			busy_run <= 0;
		end else if (o_status[3]) begin
			busy_run <= busy_run + 1;
		end else begin
			busy_run <= 0;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// ==========================================================
	// properties
	a_one_answer: assert property (i_req_valid |=> o_ack != o_refused)
		else $error("request not answered by one pulse");
	a_upper_ones: assert property (o_status[8:4] == 5'h1F)
		else $error("reserved status bits not one");
	a_net0_refuse: assert property ((put && i_req.addr inside {4'h0, 4'h2})
		##1 o_status[1] |-> o_refused)
		else $error("net0 locked write accepted");
	a_net1_refuse: assert property ((put && i_req.addr inside {4'h1, 4'h3})
		##1 o_status[2] |-> o_refused)
		else $error("net1 locked write accepted");
	a_nv_protect: assert property ((wr && nv) ##1 o_status[0] |-> o_refused)
		else $error("protected nv write accepted");
	a_busy_guard: assert property ((i_req_valid && nv) ##1 o_status[3]
		|-> o_refused)
		else $error("nv access accepted while busy");
	a_vol_open: assert property ((put && i_req.addr inside {4'h0, 4'h1})
		##1 !o_status[2] && !o_status[1] |-> o_ack)
		else $error("unlocked volatile write refused");
	a_write_busy: assert property ((wr && nv) ##1 o_ack |=> o_status[3])
		else $error("accepted nv write left busy clear");
	a_status_read: assert property (i_req_valid && i_req.addr == 4'h5
		&& i_req.cmd == nvp_pkg::NVP_CMD_READ |=> o_rdata == o_status)
		else $error("status read data wrong");
	a_hv_mirror: assert property (i_hv_valid |-> ##2
		o_status[2:1] == $past(i_hv_cfg[2:1], 2))
		else $error("lock status not mirroring hv load");
	a_busy_bound: assert property (busy_run <= NV_CYCLES)
		else $error("write cycle busy too long");
	c_hv: cover property (i_hv_valid);
	c_busy: cover property ($rose(o_status[3]));
	c_refuse: cover property (o_refused);
endmodule : nvp_guard_properties

bind nvp_guard nvp_guard_properties #(.NV_CYCLES(NV_CYCLES)) u_props (
	.i_clk(i_clk), .i_rst(i_rst), .i_req_valid(i_req_valid),
	.i_req(i_req), .i_hv_valid(i_hv_valid), .i_hv_cfg(i_hv_cfg),
	.o_ack(o_ack), .o_refused(o_refused), .o_rdata(o_rdata),
	.o_status(o_status));

// file: nvp_host.sv
// Purpose: serial host model issuing memory and hv commands
// Assumes: the answer is registered at the edge that takes the strobe
// Notes: data lines are inverted once released
`timescale 1ns/10ps
module nvp_host (
	// clock
	input wire logic i_clk,
	// requests
	output nvp_pkg::nvp_req_t o_req,
	output logic o_req_valid,
	output logic o_hv_valid,
	output nvp_pkg::nvp_cfg_t o_hv_cfg
);
	initial begin
		o_req = '0;
		o_req_valid = 1'b0;
		o_hv_valid = 1'b0;
		o_hv_cfg = '0;
	end
	task automatic send(input nvp_pkg::nvp_req_t r);
		@(posedge i_clk);
		#2;
		o_req = r;
		o_req_valid = 1'b1;
		@(posedge i_clk);
		#2;
		o_req_valid = 1'b0;
		o_req.data = ~r.data;
	endtask : send
	// hidden bits move by hv only
	task automatic hv(input nvp_pkg::nvp_cfg_t c);
		@(posedge i_clk);
		#2;
		o_hv_cfg = c;
		o_hv_valid = 1'b1;
		@(posedge i_clk);
		#2;
		o_hv_valid = 1'b0;
		o_hv_cfg = ~c;
		repeat (2) @(posedge i_clk);
		#2;
	endtask : hv
endmodule : nvp_host

// file: nvp_guard_test.sv
// Purpose: self-checking bench for the nv write-protect guard
// Assumes: nv write cycle shortened to 10 clocks
// Notes: all tasks return 2 ns after a rising edge
`timescale 1ns/10ps
module nvp_guard_test;
	localparam nvp_pkg::nvp_cmd_t WR = nvp_pkg::NVP_CMD_WRITE;
	localparam nvp_pkg::nvp_cmd_t RD = nvp_pkg::NVP_CMD_READ;
	localparam nvp_pkg::nvp_cmd_t INC = nvp_pkg::NVP_CMD_INC;
	localparam nvp_pkg::nvp_cmd_t DEC = nvp_pkg::NVP_CMD_DEC;
	logic i_clk, i_rst, i_protect_n, req_valid, hv_valid, ack, refused;
	nvp_pkg::nvp_req_t req;
	nvp_pkg::nvp_cfg_t hv_cfg;
	nvp_pkg::nvp_cfg_t cfg_nv;
	logic [8:0] rdata, w0, w1, tc, st;
	int err_total = 0;
	int checked = 0;
	nvp_host host (.i_clk(i_clk), .o_req(req), .o_req_valid(req_valid),
		.o_hv_valid(hv_valid), .o_hv_cfg(hv_cfg));
	nvp_guard #(.NV_CYCLES(10)) uut (.i_clk(i_clk), .i_rst(i_rst),
		.i_protect_n(i_protect_n), .i_req_valid(req_valid), .i_req(req),
		.i_hv_valid(hv_valid), .i_hv_cfg(hv_cfg), .i_cfg_nv(cfg_nv),
		.o_ack(ack), .o_refused(refused), .o_rdata(rdata), .o_wiper0(w0),
		.o_wiper1(w1), .o_term_ctrl(tc), .o_status(st));
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	// ==========================================================
	// helpers
	task automatic print_verdict;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#2;
	endtask : tick
	// e is {ack, refused}
	task automatic op(input nvp_pkg::nvp_cmd_t c, input logic [3:0] a,
		input logic [8:0] d, input logic [1:0] e);
		host.send({c, a, d});
		chk({7'h00, ack, refused}, {7'h00, e});
	endtask : op
	// ==========================================================
	// scenarios
	task automatic t_lock0;
		chk(st, 9'h1F2);
		op(WR, 4'h0, 9'h055, 2'h1);
		op(INC, 4'h2, 9'h000, 2'h1);
		op(WR, 4'h4, 9'h000, 2'h2);
		tick(1);
		chk(tc, 9'h00F);
		op(RD, 4'h5, 9'h000, 2'h2);
		chk(rdata, 9'h1F2);
		op(WR, 4'h5, 9'h000, 2'h2);
		tick(1);
		chk(st, 9'h1F2);
	endtask : t_lock0
	task automatic t_lock1;
		host.hv(3'h4);
		chk(st, 9'h1F4);
		op(WR, 4'h0, 9'h055, 2'h2);
		tick(1);
		chk(w0, 9'h055);
		op(DEC, 4'h1, 9'h000, 2'h1);
		op(WR, 4'h3, 9'h011, 2'h1);
		op(WR, 4'h4, 9'h1FF, 2'h2);
		tick(1);
		chk(tc, 9'h10F);
	endtask : t_lock1
	task automatic t_protect;
		host.hv(3'h1);
		chk(st, 9'h1F1);
		op(WR, 4'h6, 9'h0AA, 2'h1);
		op(INC, 4'h1, 9'h000, 2'h2);
		tick(1);
		chk(w1, 9'h081);
		chk(st, 9'h1F1);
		host.hv(3'h0);
		i_protect_n = 1'b0;
		tick(5);
		chk(st, 9'h1F1);
		op(WR, 4'h2, 9'h033, 2'h1);
		i_protect_n = 1'b1;
		tick(5);
	endtask : t_protect
	task automatic t_nv;
		int n;
		op(WR, 4'h6, 9'h123, 2'h2);
		tick(1);
		chk(st, 9'h1F8);
		op(RD, 4'h6, 9'h000, 2'h1);
		op(RD, 4'h5, 9'h000, 2'h2);
		chk(rdata, 9'h1F8);
		n = 0;
		while (st[3] !== 1'b0 && n < 50) begin
			tick(1);
			n++;
		end
		if (n == 50) begin
			err_total++;
			print_verdict();
		end
		op(RD, 4'h6, 9'h000, 2'h2);
		chk(rdata, 9'h123);
	endtask : t_nv
	task automatic t_reload;
		cfg_nv = 3'h5;
		i_rst = 1'b1;
		tick(2);
		chk(st, 9'h1F0);
		chk(w0, 9'h080);
		chk(tc, 9'h1FF);
		i_rst = 1'b0;
		tick(3);
		chk(st, 9'h1F5);
		op(WR, 4'h1, 9'h044, 2'h1);
		op(WR, 4'h7, 9'h044, 2'h1);
		op(WR, 4'h0, 9'h1FF, 2'h2);
		op(INC, 4'h0, 9'h000, 2'h2);
		tick(1);
		chk(w0, 9'h1FF);
		op(WR, 4'h0, 9'h000, 2'h2);
		op(DEC, 4'h0, 9'h000, 2'h2);
		tick(1);
		chk(w0, 9'h000);
	endtask : t_reload
	initial begin
		i_rst = 1'b1;
		i_protect_n = 1'b1;
		cfg_nv = 3'h2;
		tick(10);
		i_rst = 1'b0;
		tick(3);
		t_lock0();
		t_lock1();
		t_protect();
		t_nv();
		t_reload();
		print_verdict();
	end
endmodule : nvp_guard_test
